// ---- sfm_ctrl.sv ----
// Controller that drives a serial-access frame memory through its pins
// Behaviour
// - Eight bytes out after read strobe; ninth unused
// - Cycle starts on enable fall, select high
// - Write enable high reads, low writes
// - Read strobe waits read-strobe delay
// - Write enable low early, strobe in time
// - 1,080 refresh cycles every 4ms
// - Refresh location: row 0-269, column 0-3
// - Normal accesses may replace refresh; the controller still runs every refresh cycle
// - Select held high during refresh
// - Over eight dummy cycles before use
module sfm_ctrl
  import sfm_pkg::*;
(
  // Clocks and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              link_clk_in,
  // User request
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [63:0]       req_wdata_in,
  input  wire logic              cfg_dir_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [63:0]            rsp_rdata_out,
  output logic                   rsp_error_out,
  // Memory strobes and address
  output logic                   chip_enable_n_out,
  output logic                   chip_select_out,
  output logic                   write_enable_n_out,
  output logic                   write_strobe_n_out,
  output logic                   read_strobe_n_out,
  output logic                   output_enable_n_out,
  output logic                   output_force_control_n_out,
  output logic                   port_direction_select_out,
  output logic [ADDR_W-1:0]      address_bus_out,
  output logic                   serial_in_clock_out,
  output logic                   serial_out_clock_out,
  // Data ports, two-way
  input  wire logic [7:0]        port_a_data_in,
  output logic [7:0]             port_a_data_out,
  output logic                   port_a_data_oe_out,
  input  wire logic [7:0]        port_b_data_in,
  output logic [7:0]             port_b_data_out,
  output logic                   port_b_data_oe_out
);
  sfm_state_e        st_r, st_nxt;
  sfm_op_e           op_r, op_nxt;
  logic [TMR_W-1:0]  tmr_r, tmr_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [63:0]       wbuf_r, wbuf_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [REF_W-1:0]  ref_loc_r, ref_loc_nxt;
  logic [TMR_W-1:0]  ref_tmr_r, ref_tmr_nxt;
  logic              ref_due_r, ref_due_nxt;
  logic              init_done_r, init_done_nxt;
  logic              ce_n_r, ce_n_nxt;
  logic              cs_r, cs_nxt;
  logic              we_n_r, we_n_nxt;
  logic              ws_n_r, ws_n_nxt;
  logic              rs_n_r, rs_n_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic              sic_r, sic_nxt;
  logic              soc_r, soc_nxt;
  logic [7:0]        dout_r, dout_nxt;
  logic              dir_r, dir_nxt;
  logic              ready_r, ready_nxt;
  logic              rsp_v_r, rsp_v_nxt;
  logic              rsp_e_r, rsp_e_nxt;
  logic [63:0]       rdata_r, rdata_nxt;
  logic              arm_tgl_r, arm_tgl_nxt;
  logic              cap_done;
  logic [63:0]       cap_word;
  logic [7:0]        rd_byte;
  logic              soc_l_q1, soc_l_q2, soc_l_q3;
  logic [7:0]        rd_l_q1, rd_l_q2;
  logic              ser_en;

  // Row and column both inside the populated space
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a[ROW_W-1:0] <= ROW_LAST) && (a[ADDR_W-1:ROW_W] <= COL_LAST);
  endfunction

  // Refresh location onto address: row low bits, column next two
  function automatic logic [ADDR_W-1:0] ref_addr(input logic [REF_W-1:0] l);
    return {{(ADDR_W-REF_W){1'b0}}, l};
  endfunction

  function automatic logic [REF_W-1:0] ref_next(input logic [REF_W-1:0] l);
    logic [REF_W-1:0] n;
    n = l;
    if (l[ROW_W-1:0] < ROW_LAST)
      n[ROW_W-1:0] = l[ROW_W-1:0] + 9'h1;
    else
    begin
      n[ROW_W-1:0] = 9'h0;
      n[REF_W-1:ROW_W] = (l[REF_W-1:ROW_W] == REF_COL_LAST) ? 2'h0 : l[REF_W-1:ROW_W] + 2'h1;
    end
    return n;
  endfunction

  // Read port follows direction: high means port B drives out
  assign rd_byte = dir_r ? port_b_data_in : port_a_data_in;

  // Serial-out half period, counted from one past the read strobe's end
  assign ser_en = (tmr_r == TMR_W'(STROBE_W_CYC + SER_HALF_CYC));

  sfm_rd_capture u_cap (
    .link_clk_in (link_clk_in),
    .link_rst_in (~init_done_r),
    .arm_tgl_in  (arm_tgl_r),
    .so_rise_in  (soc_l_q2 & ~soc_l_q3),
    .byte_in     (rd_l_q2),
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .done_out    (cap_done),
    .word_out    (cap_word)
  );

  // Link-domain view of the serial-out clock, for sampling data
  always_ff @(posedge link_clk_in)
  begin
    soc_l_q1 <= soc_r;
    soc_l_q2 <= soc_l_q1;
    soc_l_q3 <= soc_l_q2;
    rd_l_q1  <= rd_byte;
    rd_l_q2  <= rd_l_q1;
  end

  always_comb
  begin
    st_nxt = st_r;   op_nxt = op_r;     tmr_nxt = tmr_r + TMR_W'(1);
    cnt_nxt = cnt_r; wbuf_nxt = wbuf_r; addr_nxt = addr_r;
    ref_loc_nxt = ref_loc_r; init_done_nxt = init_done_r;
    ce_n_nxt = ce_n_r; cs_nxt = cs_r; we_n_nxt = we_n_r;
    ws_n_nxt = ws_n_r; rs_n_nxt = rs_n_r; oe_n_nxt = oe_n_r;
    sic_nxt = sic_r;   soc_nxt = soc_r;   dout_nxt = dout_r;
    dir_nxt = dir_r;   ready_nxt = 1'b0;
    rsp_v_nxt = 1'b0;  rsp_e_nxt = 1'b0;  rdata_nxt = rdata_r;
    arm_tgl_nxt = arm_tgl_r;
    ref_due_nxt = ref_due_r;
    ref_tmr_nxt = ref_tmr_r + TMR_W'(1);
    unique case (st_r)
      SFM_IDLE:
      begin
        tmr_nxt = '0;
        cnt_nxt = '0;
        if (!init_done_r)
        begin
          st_nxt = SFM_DUMMY;
        end
        else if (ref_due_r)
        begin
          op_nxt = SFM_OP_REF;
          addr_nxt = ref_addr(ref_loc_r);
          ref_loc_nxt = ref_next(ref_loc_r);
          ref_due_nxt = 1'b0;
          cs_nxt = 1'b1;
          we_n_nxt = 1'b1;
          st_nxt = SFM_CE_LOW;
        end
        else if (ready_r && req_valid_in)
        begin
          if (!addr_ok(req_addr_in))
          begin
            rsp_v_nxt = 1'b1;
            rsp_e_nxt = 1'b1;
          end
          else
          begin
            addr_nxt = req_addr_in;
            dir_nxt  = cfg_dir_in;
            cs_nxt   = 1'b1;
            if (req_write_in)
            begin
              op_nxt = SFM_OP_WRITE;
              wbuf_nxt = req_wdata_in;
              st_nxt = SFM_SHIFTIN;
            end
            else
            begin
              op_nxt = SFM_OP_READ;
              we_n_nxt = 1'b1;
              oe_n_nxt = 1'b0;
              st_nxt = SFM_CE_LOW;
            end
          end
        end
        else
          ready_nxt = 1'b1;
      end
      SFM_DUMMY:
      begin
        // Toggle enable and both shift clocks through nine full cycles
        if (tmr_r == TMR_W'(SER_HALF_CYC - 1))
        begin
          tmr_nxt = '0;
          ce_n_nxt = ~ce_n_r;
          sic_nxt = ~sic_r;
          soc_nxt = ~soc_r;
          if (!ce_n_r)
          begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(DUMMY_CYCLES - 1))
            begin
              init_done_nxt = 1'b1;
              st_nxt = SFM_IDLE;
            end
          end
        end
      end
      SFM_SHIFTIN:
      begin
        // Data change one cycle after a fall, well before the next rise
        dout_nxt = wbuf_r[63:56];
        if (tmr_r == TMR_W'(SER_HALF_CYC - 1))
        begin
          tmr_nxt = '0;
          if (sic_r)
          begin
            sic_nxt = 1'b0;
            wbuf_nxt = {wbuf_r[55:0], 8'h00};
          end
          else if (cnt_r == 4'(BYTES_PER_ACCESS))
          begin
            cnt_nxt = '0;
            we_n_nxt = 1'b0;
            st_nxt = SFM_CE_LOW;
          end
          else
          begin
            sic_nxt = 1'b1;
            cnt_nxt = cnt_r + 4'h1;
          end
        end
      end
      SFM_CE_LOW:
      begin
        ce_n_nxt = 1'b0;
        tmr_nxt = '0;
        unique case (op_r)
          SFM_OP_WRITE: st_nxt = SFM_WS_LOW;
          SFM_OP_READ:  st_nxt = SFM_RS_WAIT;
          default:      st_nxt = SFM_CE_HIGH;
        endcase
      end
      SFM_WS_LOW:
      begin
        ws_n_nxt = (tmr_r >= TMR_W'(STROBE_W_CYC));
        if (tmr_r >= TMR_W'(WE_HOLD_CYC))
          st_nxt = SFM_CE_HIGH;
      end
      SFM_RS_WAIT:
      begin
        if (tmr_r >= TMR_W'(CE_PULSE_CYC))
          ce_n_nxt = 1'b1;
        if (tmr_r == TMR_W'(RS_DELAY_CYC - 1))
        begin
          rs_n_nxt = 1'b0;
          tmr_nxt = '0;
          st_nxt = SFM_RS_LOW;
        end
      end
      SFM_RS_LOW:
      begin
        if (tmr_r == TMR_W'(STROBE_W_CYC))
        begin
          rs_n_nxt = 1'b1;
          arm_tgl_nxt = ~arm_tgl_r;
          cnt_nxt = '0;
        end
        // Serial-out clock: eight rises only, a ninth byte is never read
        if (tmr_r > TMR_W'(STROBE_W_CYC) && ser_en)
        begin
          tmr_nxt = TMR_W'(STROBE_W_CYC + 1);
          if (soc_r)
            soc_nxt = 1'b0;
          else if (cnt_r < 4'(BYTES_PER_ACCESS))
          begin
            soc_nxt = 1'b1;
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        if (cap_done)
        begin
          rdata_nxt = cap_word;
          rsp_v_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          soc_nxt = 1'b0;
          tmr_nxt = '0;
          st_nxt = SFM_PRECH;
        end
      end
      SFM_CE_HIGH:
      begin
        if (tmr_r >= TMR_W'(CE_PULSE_CYC))
        begin
          ce_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          if (op_r == SFM_OP_WRITE)
            rsp_v_nxt = 1'b1;
          tmr_nxt = '0;
          st_nxt = SFM_PRECH;
        end
      end
      SFM_PRECH:
      begin
        ce_n_nxt = 1'b1;
        if (tmr_r == TMR_W'(CE_PRECH_CYC))
        begin
          cs_nxt = 1'b0;
          st_nxt = SFM_IDLE;
        end
      end
      default:
        st_nxt = SFM_IDLE;
    endcase
    // Set last so it wins over a same-cycle clear; ready drops so no request is lost
    if (ref_tmr_r == TMR_W'(REF_INTERVAL_CYC - 1))
    begin
      ref_tmr_nxt = '0;
      ref_due_nxt = 1'b1;
      ready_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_r <= SFM_IDLE;      op_r <= SFM_OP_READ;    tmr_r <= '0;
      cnt_r <= '0;           wbuf_r <= '0;           addr_r <= '0;
      ref_loc_r <= '0;       ref_tmr_r <= '0;        ref_due_r <= 1'b0;
      init_done_r <= 1'b0;   ce_n_r <= 1'b1;         cs_r <= 1'b0;
      we_n_r <= 1'b1;        ws_n_r <= 1'b1;         rs_n_r <= 1'b1;
      oe_n_r <= 1'b1;        sic_r <= 1'b0;          soc_r <= 1'b0;
      dout_r <= '0;          dir_r <= 1'b1;          ready_r <= 1'b0;
      rsp_v_r <= 1'b0;       rsp_e_r <= 1'b0;        rdata_r <= '0;
      arm_tgl_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;        op_r <= op_nxt;         tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;      wbuf_r <= wbuf_nxt;     addr_r <= addr_nxt;
      ref_loc_r <= ref_loc_nxt; ref_tmr_r <= ref_tmr_nxt; ref_due_r <= ref_due_nxt;
      init_done_r <= init_done_nxt; ce_n_r <= ce_n_nxt; cs_r <= cs_nxt;
      we_n_r <= we_n_nxt;    ws_n_r <= ws_n_nxt;     rs_n_r <= rs_n_nxt;
      oe_n_r <= oe_n_nxt;    sic_r <= sic_nxt;       soc_r <= soc_nxt;
      dout_r <= dout_nxt;    dir_r <= dir_nxt;       ready_r <= ready_nxt;
      rsp_v_r <= rsp_v_nxt;  rsp_e_r <= rsp_e_nxt;   rdata_r <= rdata_nxt;
      arm_tgl_r <= arm_tgl_nxt;
    end
  end

  assign req_ready_out              = ready_r;
  assign rsp_valid_out              = rsp_v_r;
  assign rsp_error_out              = rsp_e_r;
  assign rsp_rdata_out              = rdata_r;
  assign chip_enable_n_out          = ce_n_r;
  assign chip_select_out            = cs_r;
  assign write_enable_n_out         = we_n_r;
  assign write_strobe_n_out         = ws_n_r;
  assign read_strobe_n_out          = rs_n_r;
  assign output_enable_n_out        = oe_n_r;
  assign output_force_control_n_out = 1'b0;
  assign port_direction_select_out  = dir_r;
  assign address_bus_out            = addr_r;
  assign serial_in_clock_out        = sic_r;
  assign serial_out_clock_out       = soc_r;
  // Drive the memory's input port only: high dir means port A is its input
  assign port_a_data_out            = dout_r;
  assign port_b_data_out            = dout_r;
  assign port_a_data_oe_out         = dir_r;
  assign port_b_data_oe_out         = ~dir_r;
endmodule

// ---- sfm_pkg.sv ----
// Package: constants for the serial frame memory controller
package sfm_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned BYTES_PER_ACCESS = 8;
  localparam int unsigned ADDR_W           = 18;
  localparam int unsigned ROW_W            = 9;
  localparam int unsigned REF_W            = 11;
  localparam logic [8:0]  ROW_LAST         = 9'h10D;
  localparam logic [8:0]  COL_LAST         = 9'h14F;
  localparam logic [1:0]  REF_COL_LAST     = 2'h3;
  localparam int unsigned REF_COUNT        = 1080;
  localparam int unsigned REF_PERIOD_NS    = 4000000;
  localparam int unsigned DUMMY_CYCLES     = 9;
  // Strobe timing, ns
  localparam int unsigned CE_PULSE_NS      = 80;
  localparam int unsigned CE_PRECH_NS      = 100;
  localparam int unsigned RS_DELAY_NS      = 140;
  localparam int unsigned STROBE_W_NS      = 30;
  localparam int unsigned WE_HOLD_NS       = 125;
  localparam int unsigned ADDR_HOLD_NS     = 30;
  localparam int unsigned SER_HALF_NS      = 100;
  // Least times round up to cycles
  function automatic int unsigned ns2cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned CE_PULSE_CYC  = ns2cyc(CE_PULSE_NS);
  localparam int unsigned CE_PRECH_CYC  = ns2cyc(CE_PRECH_NS);
  localparam int unsigned RS_DELAY_CYC  = ns2cyc(RS_DELAY_NS);
  localparam int unsigned STROBE_W_CYC  = ns2cyc(STROBE_W_NS);
  localparam int unsigned WE_HOLD_CYC   = ns2cyc(WE_HOLD_NS);
  localparam int unsigned SER_HALF_CYC  = ns2cyc(SER_HALF_NS);
  // Refresh interval: longest time rounds down
  localparam int unsigned REF_INTERVAL_CYC = (REF_PERIOD_NS / REF_COUNT) * 1000 / CLK_PERIOD_PS;
  localparam int unsigned TMR_W         = 16;
  typedef enum logic [3:0] {
    SFM_IDLE    = 4'h0,
    SFM_DUMMY   = 4'h1,
    SFM_SHIFTIN = 4'h2,
    SFM_CE_LOW  = 4'h3,
    SFM_WS_LOW  = 4'h4,
    SFM_RS_WAIT = 4'h5,
    SFM_RS_LOW  = 4'h6,
    SFM_CE_HIGH = 4'h7,
    SFM_PRECH   = 4'h8
  } sfm_state_e;
  typedef enum logic [1:0] {
    SFM_OP_READ  = 2'h0,
    SFM_OP_WRITE = 2'h1,
    SFM_OP_REF   = 2'h2
  } sfm_op_e;
endpackage

// ---- sfm_rd_capture.sv ----
// Serial-out capture: collects eight bytes on the link clock, hands the word over
module sfm_rd_capture
  import sfm_pkg::*;
(
  // Link side
  input  wire logic        link_clk_in,
  input  wire logic        link_rst_in,
  input  wire logic        arm_tgl_in,
  input  wire logic        so_rise_in,
  input  wire logic [7:0]  byte_in,
  // Main side
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  output logic             done_out,
  output logic [63:0]      word_out
);
  logic [1:0]  arm_sync_r;
  logic [1:0]  lrst_sync_r;
  logic        arm_seen_r;
  logic        arm_seen_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [63:0] buf_r;
  logic [63:0] buf_nxt;
  logic        done_tgl_r;
  logic        done_tgl_nxt;
  logic [2:0]  done_sync_r;
  logic        done_r;
  logic [63:0] word_r;

  // Link domain: count bytes after each arm event
  always_comb
  begin
    arm_seen_nxt = arm_sync_r[1];
    cnt_nxt      = cnt_r;
    buf_nxt      = buf_r;
    done_tgl_nxt = done_tgl_r;
    if (arm_sync_r[1] != arm_seen_r)
      cnt_nxt = 4'h0;
    else if (so_rise_in && cnt_r < 4'(BYTES_PER_ACCESS))
    begin
      buf_nxt = {buf_r[55:0], byte_in};
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == 4'(BYTES_PER_ACCESS - 1))
        done_tgl_nxt = ~done_tgl_r;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    lrst_sync_r <= {lrst_sync_r[0], link_rst_in};      // Reset crosses through two flip-flops
    if (lrst_sync_r[1])
    begin
      arm_sync_r <= 2'h0;
      arm_seen_r <= 1'b0;
      cnt_r      <= 4'(BYTES_PER_ACCESS);
      buf_r      <= 64'h0;
      done_tgl_r <= 1'b0;
    end
    else
    begin
      arm_sync_r <= {arm_sync_r[0], arm_tgl_in};
      arm_seen_r <= arm_seen_nxt;
      cnt_r      <= cnt_nxt;
      buf_r      <= buf_nxt;
      done_tgl_r <= done_tgl_nxt;
    end
  end

  // Main domain: toggle synchroniser, word stable once toggle lands
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      done_sync_r <= 3'h0;
      done_r      <= 1'b0;
      word_r      <= 64'h0;
    end
    else
    begin
      done_sync_r <= {done_sync_r[1:0], done_tgl_r};
      done_r      <= done_sync_r[2] ^ done_sync_r[1];
      if (done_sync_r[2] ^ done_sync_r[1])
        word_r <= buf_r;
    end
  end

  assign done_out = done_r;
  assign word_out = word_r;
endmodule

// ---- sfm_ctrl_props.sv ----
// Assertions on the frame memory controller pins
module sfm_ctrl_props
  import sfm_pkg::*;
(
  // Clock, reset and user side
  input wire logic              mclk_in,
  input wire logic              rst_in,
  input wire logic              req_ready_out,
  input wire logic              rsp_valid_out,
  input wire logic              rsp_error_out,
  // Memory pins
  input wire logic              chip_enable_n_out,
  input wire logic              chip_select_out,
  input wire logic              write_enable_n_out,
  input wire logic              write_strobe_n_out,
  input wire logic              read_strobe_n_out,
  input wire logic              port_direction_select_out,
  input wire logic [ADDR_W-1:0] address_bus_out,
  input wire logic              port_a_data_oe_out,
  input wire logic              port_b_data_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned GAP_MAX = REF_INTERVAL_CYC + 20 * SER_HALF_CYC;
  logic             up_r;
  logic             up_nxt;
  logic [TMR_W-1:0] gap_r;
  logic [TMR_W-1:0] gap_nxt;
  // Cycles since enable was last low; up once ready has been seen
  always_comb
  begin
    up_nxt  = (up_r | req_ready_out) & ~rst_in;
    gap_nxt = (rst_in | ~chip_enable_n_out) ? '0 : gap_r + TMR_W'(1);
  end
  always_ff @(posedge mclk_in)
  begin
    up_r  <= up_nxt;
    gap_r <= gap_nxt;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  reset_idle_a: assert property ($fell(rst_in) |-> chip_enable_n_out && !chip_select_out ##0 !req_ready_out [*8])
    else $error("strobe or ready active after reset");
  ce_select_a: assert property ($fell(chip_enable_n_out) && up_r |-> chip_select_out)
    else $error("enable fell without select");
  addr_hold_a: assert property ($fell(chip_enable_n_out) && up_r |=>
    ($stable(address_bus_out) && $stable(chip_select_out)) [*7])
    else $error("address moved in hold time");
  addr_range_a: assert property ($fell(chip_enable_n_out) && chip_select_out |->
    address_bus_out[ROW_W-1:0] <= ROW_LAST && address_bus_out[ADDR_W-1:ROW_W] <= COL_LAST)
    else $error("cycle on absent address");
  rd_delay_a: assert property ($fell(chip_enable_n_out) && chip_select_out && write_enable_n_out |=>
    read_strobe_n_out [*8] ##1 read_strobe_n_out [*8] ##1 read_strobe_n_out [*8] ##1 read_strobe_n_out [*8]
    ##1 read_strobe_n_out [*2])
    else $error("read strobe too early");
  ws_we_a: assert property ($fell(write_strobe_n_out) |-> !write_enable_n_out)
    else $error("write strobe outside write cycle");
  rs_we_a: assert property ($fell(read_strobe_n_out) |-> write_enable_n_out)
    else $error("read strobe in write cycle");
  refresh_gap_a: assert property (gap_r <= GAP_MAX)
    else $error("refresh overdue");
  err_pulse_a: assert property (rsp_error_out |-> rsp_valid_out ##1 !rsp_valid_out)
    else $error("error without one-cycle response");
  port_dir_a: assert property (port_a_data_oe_out || port_b_data_oe_out |->
    port_a_data_oe_out == port_direction_select_out && port_b_data_oe_out != port_direction_select_out)
    else $error("driving the memory output port");
endmodule

bind sfm_ctrl sfm_ctrl_props u_props (.mclk_in, .rst_in, .req_ready_out, .rsp_valid_out, .rsp_error_out,
  .chip_enable_n_out, .chip_select_out, .write_enable_n_out, .write_strobe_n_out, .read_strobe_n_out,
  .port_direction_select_out, .address_bus_out, .port_a_data_oe_out, .port_b_data_oe_out);

// ---- sfm_mem_model.sv ----
// Behavioural serial frame memory reacting to its own strobe and clock edges
module sfm_mem_model
  import sfm_pkg::*;
(
  // Strobes and address
  input  wire logic              ce_n_in,
  input  wire logic              cs_in,
  input  wire logic              we_n_in,
  input  wire logic              ws_n_in,
  input  wire logic              rs_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              force_n_in,
  input  wire logic              dir_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // Serial ports
  input  wire logic              sic_in,
  input  wire logic              soc_in,
  input  wire logic [7:0]        a_in,
  input  wire logic [7:0]        b_in,
  output logic      [7:0]        q_out,
  output logic                   drv_a_out,
  output logic                   drv_b_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0]       mem [logic [ADDR_W-1:0]];
  logic [63:0]       sin_r;
  logic [63:0]       latch_r;
  logic [63:0]       sout_r = '0;
  logic [7:0]        q_r = 8'h00;
  logic [ADDR_W-1:0] adr_r;
  logic              sel_r = 1'b0;
  logic              wr_r = 1'b0;
  int                dummies = 0;
  int                viol = 0;
  int                selected = 0;
  int                accesses = 0;
  realtime           t_ce = 0;
  // First byte in ends on top after eight clocks
  always @(posedge sic_in) sin_r <= {sin_r[55:0], dir_in ? a_in : b_in};
  always @(negedge ce_n_in)
  begin
    t_ce = $realtime;
    adr_r = addr_in;
    wr_r = !we_n_in;
    sel_r = cs_in && addr_in[8:0] <= ROW_LAST && addr_in[17:9] <= COL_LAST;
    if (sel_r)
      selected++;
    if (!cs_in)
      dummies++;
    else if (dummies < 9 || !sel_r)
      viol++;
  end
  always @(negedge ws_n_in) latch_r = sin_r;
  always @(posedge ce_n_in)
    if (sel_r && wr_r)
    begin
      mem[adr_r] = latch_r;
      accesses++;
    end
  always @(negedge rs_n_in)
  begin
    if ($realtime - t_ce < RS_DELAY_NS || wr_r)
      viol++;
    latch_r = (sel_r && mem.exists(adr_r)) ? mem[adr_r] : ~sin_r;
    sout_r = latch_r;
    if (sel_r)
      accesses++;
  end
  // Past the eighth byte, inverted bytes come round
  always @(posedge soc_in)
  begin
    q_r = sout_r[63:56];
    sout_r = {sout_r[55:0], ~sout_r[63:56]};
  end
  assign q_out     = force_n_in ? 8'h00 : q_r;
  assign drv_a_out = !oe_n_in && !dir_in;
  assign drv_b_out = !oe_n_in && dir_in;
endmodule

// ---- tb_top.sv ----
// Bench: frame memory controller against a behavioural memory model
module tb_top
  import sfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              mclk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              link_clk_in = 1'b0;
  logic              req_valid_in = 1'b0;
  logic              req_write_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = '0;
  logic [63:0]       req_wdata_in = '0;
  logic              cfg_dir_in = 1'b1;
  logic              req_ready_out, rsp_valid_out, rsp_error_out, chip_enable_n_out, chip_select_out;
  logic              write_enable_n_out, write_strobe_n_out, read_strobe_n_out, output_enable_n_out;
  logic              output_force_control_n_out, port_direction_select_out, serial_in_clock_out;
  logic              serial_out_clock_out, port_a_data_oe_out, port_b_data_oe_out, mem_drv_a, mem_drv_b;
  logic [ADDR_W-1:0] address_bus_out;
  logic [63:0]       rsp_rdata_out, rd;
  logic [7:0]        port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out, mem_q;
  logic              err;
  int                mismatches = 0;
  int                total_checks = 0;
  // Data pins are pulled down when nobody drives them
  assign port_a_data_in = port_a_data_oe_out ? port_a_data_out : mem_drv_a ? mem_q : 8'h00;
  assign port_b_data_in = port_b_data_oe_out ? port_b_data_out : mem_drv_b ? mem_q : 8'h00;
  initial forever #2 mclk_in = ~mclk_in;
  initial
  begin
    #13;
    forever #40 link_clk_in = ~link_clk_in;
  end
  sfm_ctrl dut (
    .mclk_in, .rst_in, .link_clk_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in, .cfg_dir_in,
    .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .rsp_error_out, .chip_enable_n_out, .chip_select_out,
    .write_enable_n_out, .write_strobe_n_out, .read_strobe_n_out, .output_enable_n_out,
    .output_force_control_n_out, .port_direction_select_out, .address_bus_out, .serial_in_clock_out,
    .serial_out_clock_out, .port_a_data_in, .port_a_data_out, .port_a_data_oe_out, .port_b_data_in,
    .port_b_data_out, .port_b_data_oe_out);
  sfm_mem_model u_mem (
    .ce_n_in(chip_enable_n_out), .cs_in(chip_select_out), .we_n_in(write_enable_n_out),
    .ws_n_in(write_strobe_n_out), .rs_n_in(read_strobe_n_out), .oe_n_in(output_enable_n_out),
    .force_n_in(output_force_control_n_out), .dir_in(port_direction_select_out), .addr_in(address_bus_out),
    .sic_in(serial_in_clock_out), .soc_in(serial_out_clock_out), .a_in(port_a_data_in), .b_in(port_b_data_in),
    .q_out(mem_q), .drv_a_out(mem_drv_a), .drv_b_out(mem_drv_b));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [63:0] pat(input int i, input logic dir);
    return 64'h0123456789ABCDEF ^ {8{dir, 7'(i)}};
  endfunction
  // One request held until taken, then its response; entered and left at a falling edge
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] adr, input logic [63:0] wd, input logic dir);
    int n;
    req_valid_in = 1'b1;
    req_write_in = wr;
    req_addr_in  = adr;
    req_wdata_in = wd;
    cfg_dir_in   = dir;
    @(posedge mclk_in);
    for (n = 0; n < 5000 && req_ready_out !== 1'b1; n++) @(posedge mclk_in);
    @(negedge mclk_in);
    req_valid_in = 1'b0;
    for (n = 0; n < 5000 && rsp_valid_out !== 1'b1; n++) @(negedge mclk_in);
    check("response", n < 5000, 1'b1);
    rd  = rsp_rdata_out;
    err = rsp_error_out;
  endtask
  task automatic t_reset();
    repeat (6) @(negedge mclk_in);
    check("enable in reset", chip_enable_n_out, 1'b1);
    check("ready in reset", req_ready_out, 1'b0);
    rst_in = 1'b0;
    for (int n = 0; n < 2000 && req_ready_out !== 1'b1; n++) @(negedge mclk_in);
    check("ready after init", req_ready_out, 1'b1);
    check("dummy cycles", u_mem.dummies > 8, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_data(input logic dir);
    logic [ADDR_W-1:0] adr [3];
    adr = '{{9'h000, 9'h000}, {COL_LAST, ROW_LAST}, {9'h0A5, 9'h05A}};
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, adr[i], pat(i, dir), dir);
      check("write error flag", err, 1'b0);
    end
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b0, adr[i], '0, dir);
      check("read data", rd, pat(i, dir));
      check("read error flag", err, 1'b0);
    end
    $display("data test done, direction %0d", dir);
  endtask
  task automatic t_bad();
    logic [ADDR_W-1:0] adr [3];
    int                acc;
    adr = '{{9'h000, 9'h10E}, {9'h150, 9'h000}, {9'h1FF, 9'h1FF}};
    acc = u_mem.accesses;
    for (int i = 0; i < 3; i++)
    begin
      xfer(i[0], adr[i], pat(i, 1'b1), 1'b1);
      check("error flag", err, 1'b1);
    end
    check("array accesses", u_mem.accesses - acc, 0);
    $display("absent address test done");
  endtask
  task automatic t_refresh();
    int s0;
    int a0;
    int d0;
    s0 = u_mem.selected;
    a0 = u_mem.accesses;
    d0 = u_mem.dummies;
    repeat (2 * REF_INTERVAL_CYC + 500) @(negedge mclk_in);
    check("refresh cycles", u_mem.selected - s0 >= 2, 1'b1);
    check("no strobes in refresh", u_mem.accesses - a0, 0);
    check("select in refresh", u_mem.dummies - d0, 0);
    xfer(1'b0, {COL_LAST, ROW_LAST}, '0, 1'b0);
    check("data kept", rd, pat(1, 1'b0));
    check("memory timing faults", u_mem.viol, 0);
    $display("refresh test done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_data(1'b1);
    t_data(1'b0);
    t_bad();
    t_refresh();
    summarize();
  end
  initial
  begin
    #150000;
    mismatches++;
    summarize();
  end
endmodule
